/* verilog/wdt_ch1.sv */
// Second watchdog channel: guard counter, control registers and overflow actions.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Contract
// R1: Counter wrap FF to 00 sets wrap flag.
// R2: Wrap flag cleared by read-one then write-zero.
// R3: Internal reset action clears wrap flag.
// R4: Control bit 6: interval or watchdog mode.
// R5: Enable counts; disable stops and zeroes counter.
// R6: Control bit 4 picks main or sub prescaler.
// R7: Control bit 3: interrupt or internal reset.
// R8: Main prescaler codes divide by 2..131072.
// R9: Sub prescaler code 011 divides by 16.
// R10: Overflow period spans 256 selected ticks.
// R11: Reset control loads 1F on pin reset only.
// R12: Guard flag set only in watchdog mode.
// R13: Guard flag cleared by read-one then write-zero.
// R14: Reset enable bit 6 resets chip.
// R15: Reset type bit 5 must stay zero.
// R16: Reset control bits 4..0 read one.
// R17: Eight-bit readable writable up-counter.
// R18: Interval interrupt raised with wrap flag.
// R19: Watchdog interrupt action raises nonmaskable request.
// R20: Reset or interrupt request held 516 cycles.
// R21: Counter advances one per enabled tick.
module wdt_ch1
    import wdt_ch1_pkg::*;
#(
    parameter int HOLD = HOLD_CYCLES
) (
    // Clock and external reset pin
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    // Register port
    input  wire logic [ADDR_W-1:0]     i_reg_addr,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    input  wire logic [7:0]            i_reg_wdata,
    output logic      [7:0]            o_reg_rdata,
    // Sub-clock, sampled as a synchronous level
    input  wire logic                  i_sub_clk,
    // Requests to interrupt controller and reset logic
    output logic                       o_interval_irq,
    output logic                       o_nmi_req,
    output logic                       o_chip_reset_req
);
    import wdt_ch1_pkg::*;

    initial begin
        if (HOLD < 8) begin
            $error("wdt_ch1: HOLD must be at least eight cycles");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [COUNT_W-1:0]    guard_counter;
    logic                  count_wrap_flag;
    logic                  mode_select;
    logic                  count_enable;
    logic                  prescaler_source_select;
    logic                  overflow_action;
    logic [TICK_SEL_W-1:0] tick_select;
    logic                  wrap_armed;
    logic                  guard_overflow_flag;
    logic                  guard_armed;
    logic                  chip_reset_enable;
    logic                  reset_type_select;

    logic                  tick;
    logic                  ctrl_wr;
    logic                  cnt_wr;
    logic                  rst_wr;
    logic                  wrap;
    logic                  internal_reset;
    logic                  nmi_start;
    logic                  chip_start;
    logic                  next_wrap_flag;
    logic                  next_mode;
    logic [7:0]            control_view;
    logic [7:0]            reset_view;

    assign ctrl_wr = i_reg_wr && (i_reg_addr == ADDR_CONTROL);
    assign cnt_wr  = i_reg_wr && (i_reg_addr == ADDR_COUNTER);
    assign rst_wr  = i_reg_wr && (i_reg_addr == ADDR_RESET);

    assign control_view = {count_wrap_flag, mode_select, count_enable,
                           prescaler_source_select, overflow_action, tick_select};
    assign reset_view   = {guard_overflow_flag, chip_reset_enable, reset_type_select,
                           RESET_CTRL_ONES}; // R16

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and held requests.

    wdt_prescale u_prescale ( // R6 R8 R9
        .i_core_clk   (i_core_clk),
        .i_rst_b      (i_rst_b),
        .i_sub_clk    (i_sub_clk),
        .i_source_sel (prescaler_source_select),
        .i_tick_sel   (tick_select),
        .o_tick       (tick)
    );

    wdt_hold #(
        .HOLD (HOLD)
    ) u_nmi_hold ( // R19 R20
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_start    (nmi_start),
        .o_active   (o_nmi_req)
    );

    wdt_hold #(
        .HOLD (HOLD)
    ) u_reset_hold ( // R14 R20
        .i_core_clk (i_core_clk),
        .i_rst_b    (i_rst_b),
        .i_start    (chip_start),
        .o_active   (o_chip_reset_req)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Overflow detection and actions.

    // A software write in the same cycle as a tick wins, so the tick is lost.
    assign wrap           = count_enable && tick && !cnt_wr
                            && (guard_counter == COUNT_MAX); // R1 R10
    assign internal_reset = wrap && mode_select && overflow_action; // R4 R7
    assign nmi_start      = wrap && mode_select && !overflow_action; // R7 R19
    assign chip_start     = internal_reset && chip_reset_enable; // R14

    ////////////////////////////////////////////////////////////////////////////
    // Guard counter.

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            guard_counter <= '0;
        end else if (!count_enable || internal_reset) begin
            guard_counter <= '0; // R5 R14
        end else if (cnt_wr) begin
            guard_counter <= i_reg_wdata; // R17
        end else if (tick) begin
            guard_counter <= guard_counter + COUNT_W'(1); // R21
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register.

    always_comb begin
        next_wrap_flag = count_wrap_flag;
        if (internal_reset) begin
            next_wrap_flag = 1'b0; // R3
        end else if (wrap) begin
            next_wrap_flag = 1'b1; // R1
        end else if (ctrl_wr && !i_reg_wdata[WRAP_FLAG_BIT] && wrap_armed) begin
            next_wrap_flag = 1'b0; // R2
        end
    end

    always_comb begin
        next_mode = mode_select;
        if (internal_reset) begin
            next_mode = CONTROL_INIT[MODE_BIT];
        end else if (ctrl_wr) begin
            next_mode = i_reg_wdata[MODE_BIT];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_wrap_flag <= CONTROL_INIT[WRAP_FLAG_BIT];
            mode_select     <= CONTROL_INIT[MODE_BIT];
        end else begin
            count_wrap_flag <= next_wrap_flag;
            mode_select     <= next_mode; // R4
        end
    end

    // An internal reset caused by overflow returns the control fields to their
    // initial values, whether or not the chip itself is reset.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count_enable            <= CONTROL_INIT[ENABLE_BIT];
            prescaler_source_select <= CONTROL_INIT[SOURCE_BIT];
            overflow_action         <= CONTROL_INIT[ACTION_BIT];
            tick_select             <= CONTROL_INIT[TICK_SEL_LSB +: TICK_SEL_W];
        end else if (internal_reset) begin
            count_enable            <= CONTROL_INIT[ENABLE_BIT]; // R14
            prescaler_source_select <= CONTROL_INIT[SOURCE_BIT];
            overflow_action         <= CONTROL_INIT[ACTION_BIT];
            tick_select             <= CONTROL_INIT[TICK_SEL_LSB +: TICK_SEL_W];
        end else if (ctrl_wr) begin
            count_enable            <= i_reg_wdata[ENABLE_BIT]; // R5
            prescaler_source_select <= i_reg_wdata[SOURCE_BIT]; // R6
            overflow_action         <= i_reg_wdata[ACTION_BIT]; // R7
            tick_select             <= i_reg_wdata[TICK_SEL_LSB +: TICK_SEL_W]; // R8
        end
    end

    // The clear is armed only by a read that saw the flag at one.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wrap_armed <= 1'b0;
        end else if (ctrl_wr || internal_reset) begin
            wrap_armed <= 1'b0;
        end else if (i_reg_rd && (i_reg_addr == ADDR_CONTROL) && count_wrap_flag) begin
            wrap_armed <= 1'b1; // R2
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset control register; of the two resets only the pin reset touches it.

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            guard_overflow_flag <= RESET_CTRL_INIT[GUARD_FLAG_BIT]; // R11
        end else if (wrap && mode_select) begin
            guard_overflow_flag <= 1'b1; // R12
        end else if (rst_wr && !i_reg_wdata[GUARD_FLAG_BIT] && guard_armed) begin
            guard_overflow_flag <= 1'b0; // R13
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            guard_armed <= 1'b0;
        end else if (rst_wr) begin
            guard_armed <= 1'b0;
        end else if (i_reg_rd && (i_reg_addr == ADDR_RESET) && guard_overflow_flag) begin
            guard_armed <= 1'b1; // R13
        end
    end

    // Software keeps the reset type at zero; a one is stored but has no effect.
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            chip_reset_enable <= RESET_CTRL_INIT[CHIP_RESET_BIT]; // R11
            reset_type_select <= RESET_CTRL_INIT[RESET_TYPE_BIT];
        end else if (rst_wr) begin
            chip_reset_enable <= i_reg_wdata[CHIP_RESET_BIT]; // R14
            reset_type_select <= i_reg_wdata[RESET_TYPE_BIT]; // R15
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_interval_irq <= 1'b0;
        end else begin
            o_interval_irq <= next_wrap_flag && !next_mode; // R18
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_CONTROL: o_reg_rdata <= control_view;
                ADDR_COUNTER: o_reg_rdata <= guard_counter; // R17
                ADDR_RESET:   o_reg_rdata <= reset_view; // R16
                default:      o_reg_rdata <= 8'h00;
            endcase
        end else begin
            o_reg_rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_armed_zero_write;
        wrap_armed && ctrl_wr && !i_reg_wdata[WRAP_FLAG_BIT];
    endsequence

    chk_wrap_sets_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R1
        wrap && !internal_reset |=> count_wrap_flag && guard_counter == 8'h00)
        else $error("wrap did not set flag and zero the counter");

    chk_flag_clear_cause: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R2
        $fell(count_wrap_flag) |-> $past(wrap_armed && ctrl_wr) || $past(internal_reset))
        else $error("wrap flag cleared without armed write");

    chk_armed_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R2
        s_armed_zero_write and !wrap |=> !count_wrap_flag)
        else $error("armed zero write did not clear wrap flag");

    chk_auto_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R3
        internal_reset |=> !count_wrap_flag && !count_enable && guard_counter == 8'h00)
        else $error("internal reset left control state");

    chk_disable_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R5
        !count_enable |=> guard_counter == 8'h00)
        else $error("counter not zero while disabled");

    chk_count_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R21
        count_enable && tick && !cnt_wr && !internal_reset
        |=> guard_counter == $past(guard_counter) + 8'h01)
        else $error("counter did not advance on tick");

    chk_count_still: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R21
        count_enable && !tick && !cnt_wr && !internal_reset
        |=> guard_counter == $past(guard_counter))
        else $error("counter moved without a tick");

    chk_counter_read: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R17
        i_reg_rd && i_reg_addr == ADDR_COUNTER |=> o_reg_rdata == $past(guard_counter))
        else $error("counter read returned a stale value");

    chk_guard_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R13
        $fell(guard_overflow_flag) |-> $past(guard_armed && rst_wr))
        else $error("guard flag cleared without armed write");

    chk_reset_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R14
        chip_start |=> o_chip_reset_req [*8])
        else $error("chip reset request not raised and held");

    chk_guard_mode: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R12
        $rose(guard_overflow_flag) |-> $past(mode_select) && $past(wrap))
        else $error("guard flag set outside watchdog wrap");

    chk_reset_kept: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R11
        internal_reset && !rst_wr |=> chip_reset_enable == $past(chip_reset_enable))
        else $error("internal reset altered reset control");

    chk_reserved_ones: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R16
        i_reg_rd && i_reg_addr == ADDR_RESET |=> o_reg_rdata[4:0] == 5'h1F)
        else $error("reserved bits not read as one");

    chk_irq_flag: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R18
        o_interval_irq == (count_wrap_flag && !mode_select))
        else $error("interval request not tied to wrap flag");

    chk_nmi_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R19
        nmi_start |=> o_nmi_req [*8])
        else $error("interrupt request not raised and held");

    chk_chip_reset: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R14
        internal_reset |=> o_chip_reset_req == $past(chip_reset_enable)
                           || $past(o_chip_reset_req))
        else $error("chip reset request does not follow enable");

endmodule

/* verilog/wdt_ch1_pkg.sv */
// Shared constants for the second watchdog channel: register map, fields, timing.
package wdt_ch1_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port addresses.
    localparam int         ADDR_W        = 2;
    localparam logic [1:0] ADDR_CONTROL  = 2'h0;
    localparam logic [1:0] ADDR_COUNTER  = 2'h1;
    localparam logic [1:0] ADDR_RESET    = 2'h3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of timer_control_status.
    localparam int WRAP_FLAG_BIT   = 7;
    localparam int MODE_BIT        = 6;
    localparam int ENABLE_BIT      = 5;
    localparam int SOURCE_BIT      = 4;
    localparam int ACTION_BIT      = 3;
    localparam int TICK_SEL_LSB    = 0;
    localparam int TICK_SEL_W      = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and values of reset_control_status.
    localparam int         GUARD_FLAG_BIT   = 7;
    localparam int         CHIP_RESET_BIT   = 6;
    localparam int         RESET_TYPE_BIT   = 5;
    localparam logic [7:0] RESET_CTRL_INIT  = 8'h1F;
    localparam logic [4:0] RESET_CTRL_ONES  = 5'h1F;
    localparam logic [7:0] CONTROL_INIT     = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Counter and timing.
    localparam int         COUNT_W      = 8;
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam int         HOLD_CYCLES  = 516;
    localparam int         MAIN_DIV_W   = 17;
    localparam int         SUB_DIV_W    = 8;

    // Log2 of the main-clock divisors for tick select codes 0 to 7.
    localparam logic [4:0] MAIN_LOG2 [8] = '{5'h01, 5'h06, 5'h07, 5'h09,
                                             5'h0B, 5'h0D, 5'h0F, 5'h11};
    // Log2 of the sub-clock divisors; only code 3 (divide by 16) is fixed.
    localparam logic [4:0] SUB_LOG2 [8]  = '{5'h01, 5'h02, 5'h03, 5'h04,
                                             5'h05, 5'h06, 5'h07, 5'h08};

endpackage

/* verilog/wdt_prescale.sv */
// Two free-running prescalers and the tick selector feeding the guard counter.
`timescale 1ns/1ns
module wdt_prescale
    import wdt_ch1_pkg::*;
#(
    parameter int MAIN_W = MAIN_DIV_W,
    parameter int SUB_W  = SUB_DIV_W
) (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_b,
    // Selection
    input  wire logic                  i_sub_clk,
    input  wire logic                  i_source_sel,
    input  wire logic [TICK_SEL_W-1:0] i_tick_sel,
    // Tick out
    output logic                       o_tick
);
    import wdt_ch1_pkg::*;

    initial begin
        if (MAIN_W < 17 || SUB_W < 8 || SUB_W > MAIN_W) begin
            $error("wdt_prescale: divider widths too small");
        end
    end

    logic [MAIN_W-1:0] main_cnt;
    logic [SUB_W-1:0]  sub_cnt;
    logic              sub_prev;
    logic              sub_edge;

    // True in the last count of each 2**lg period.
    function automatic logic at_wrap(input logic [MAIN_W-1:0] cnt, input logic [4:0] lg);
        logic [MAIN_W-1:0] low_mask;
        low_mask = (MAIN_W'(1) << lg) - MAIN_W'(1);
        at_wrap  = (cnt & low_mask) == low_mask;
    endfunction

    assign sub_edge = i_sub_clk && !sub_prev;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            main_cnt <= '0;
            sub_cnt  <= '0;
            sub_prev <= 1'b0;
        end else begin
            main_cnt <= main_cnt + MAIN_W'(1);
            sub_prev <= i_sub_clk;
            if (sub_edge) begin
                sub_cnt <= sub_cnt + SUB_W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_tick <= 1'b0;
        end else if (i_source_sel) begin
            o_tick <= sub_edge && at_wrap(MAIN_W'(sub_cnt), SUB_LOG2[i_tick_sel]); // R6 R9
        end else begin
            o_tick <= at_wrap(main_cnt, MAIN_LOG2[i_tick_sel]); // R6 R8
        end
    end

endmodule

/* verilog/wdt_hold.sv */
// Stretches a one-cycle start into a request held for a fixed number of cycles.
`timescale 1ns/1ns
module wdt_hold
    import wdt_ch1_pkg::*;
#(
    parameter int HOLD = HOLD_CYCLES
) (
    // Clock and reset
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    // Start and held request
    input  wire logic i_start,
    output logic      o_active
);
    import wdt_ch1_pkg::*;

    localparam int W = $clog2(HOLD + 1);

    initial begin
        if (HOLD < 1 || HOLD > 65535) begin
            $error("wdt_hold: HOLD out of range");
        end
    end

    logic [W-1:0] remain;
    logic [W-1:0] held_len;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_active <= 1'b0;
            remain   <= '0;
        end else if (i_start) begin
            o_active <= 1'b1;
            remain   <= W'(HOLD - 1);
        end else if (o_active) begin
            if (remain == '0) begin
                o_active <= 1'b0;
            end else begin
                remain <= remain - W'(1);
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            held_len <= '0;
        end else if (i_start || !o_active) begin
            held_len <= '0;
        end else begin
            held_len <= held_len + W'(1);
        end
    end

    chk_hold_length: assert property (@(posedge i_core_clk) disable iff (!i_rst_b) // R20
        $fell(o_active) |-> held_len == W'(HOLD))
        else $error("held request length differs from HOLD");

endmodule

/* verification/wdt_host_model.sv */
// Register-port driver standing in for the CPU side of the watchdog channel.
`timescale 1ns/1ns
module wdt_host_model
    import wdt_ch1_pkg::*;
(
    // Clock
    input  wire logic                           i_core_clk,
    // Register port
    input  wire logic [7:0]                     i_reg_rdata,
    output logic      [wdt_ch1_pkg::ADDR_W-1:0] o_reg_addr,
    output logic                                o_reg_wr,
    output logic                                o_reg_rd,
    output logic      [7:0]                     o_reg_wdata
);
    import wdt_ch1_pkg::*;

    initial begin
        o_reg_addr = 2'h0;
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_wdata = 8'h00;
    end

    ////////////////////////////////////////////////////////////
    // The reset type bit is never written as one, whatever the caller asks.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_reg_addr = a;
        o_reg_wdata = (a == ADDR_RESET) ? (d & 8'hDF) : d;
        o_reg_wr = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_reg_wr = 1'b0;
        o_reg_wdata = ~o_reg_wdata;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge i_core_clk);
        #1;
        o_reg_addr = a;
        o_reg_rd = 1'b1;
        @(posedge i_core_clk);
        #1;
        o_reg_rd = 1'b0;
        d = i_reg_rdata;
    endtask

    // A flag only clears after a read that saw it set, so the clear reads first.
    task automatic clear_flag(input logic [1:0] a, input logic [7:0] keep, output logic [7:0] seen);
        rd(a, seen);
        wr(a, keep & 8'h7F);
    endtask
endmodule

/* verification/wdt_ch1_tb.sv */
// Self-checking testbench of the second watchdog channel.
`timescale 1ns/1ns
module wdt_ch1_tb;
    import wdt_ch1_pkg::*;

    localparam int HOLD_T = 8;
    localparam int DIV_TAB [6] = '{2, 64, 128, 512, 2048, 8192};

    logic        i_core_clk = 1'b0;
    logic        i_rst_b    = 1'b0;
    logic        i_sub_clk  = 1'b0;
    logic [1:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        irq;
    logic        nmi;
    logic        crst;
    logic [7:0]  d;
    logic [31:0] seed       = 32'h26C2;
    logic [1:0]  which;
    int          held;
    int          n;
    int          n_mismatch = 0;
    int          cmp_count  = 0;

    always #2 i_core_clk = ~i_core_clk;

    // Sub-clock runs at a quarter of the core rate.
    always begin
        repeat (2) @(posedge i_core_clk);
        #1;
        i_sub_clk = ~i_sub_clk;
    end

    wdt_host_model host (.i_core_clk(i_core_clk), .i_reg_rdata(reg_rdata), .o_reg_addr(reg_addr),
        .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_wdata(reg_wdata));

    wdt_ch1 #(.HOLD(HOLD_T)) dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b),
        .i_reg_addr(reg_addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata),
        .o_reg_rdata(reg_rdata), .i_sub_clk(i_sub_clk), .o_interval_irq(irq),
        .o_nmi_req(nmi), .o_chip_reset_req(crst));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic step();
        @(posedge i_core_clk);
        #1;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        cmp_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    // Starts a fast run near the top of the count and measures any held request.
    task automatic overflow(input logic [7:0] ctrl);
        host.wr(ADDR_CONTROL, 8'h00);
        host.wr(ADDR_CONTROL, ctrl);
        host.wr(ADDR_COUNTER, 8'hF0);
        n = 0;
        while (!(nmi | crst | irq) && n < 100) begin
            step();
            n++;
        end
        which = {crst, nmi};
        held = 0;
        while ((nmi | crst) && held < 600) begin
            held++;
            step();
        end
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #400000;
        n_mismatch++;
        results();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_core_clk);
        #1;
        i_rst_b = 1'b1;
        host.rd(ADDR_CONTROL, d);
        chk(d, 8'h00);
        host.wr(ADDR_RESET, 8'h00);
        host.rd(ADDR_RESET, d);
        chk(d, 8'h1F);
        host.wr(2'h2, 8'hFF);
        host.rd(2'h2, d);
        chk(d, 8'h00);
        host.wr(ADDR_COUNTER, 8'h55);
        host.rd(ADDR_COUNTER, d);
        chk(d, 8'h00);
        host.wr(ADDR_CONTROL, 8'h5F);
        host.rd(ADDR_CONTROL, d);
        chk(d, 8'h5F);
        host.wr(ADDR_CONTROL, 8'h27);
        host.rd(ADDR_CONTROL, d);
        chk(d, 8'h27);
        repeat (4) begin
            seed = xorshift(seed);
            host.wr(ADDR_COUNTER, {seed[7:1], 1'b0});
            host.rd(ADDR_COUNTER, d);
            chk_rng(d, {seed[7:1], 1'b0}, {seed[7:1], 1'b1});
        end
        for (int k = 0; k < 6; k++) begin
            host.wr(ADDR_CONTROL, 8'h00);
            host.wr(ADDR_CONTROL, 8'h20 | 8'(k));
            repeat (4 * DIV_TAB[k]) @(posedge i_core_clk);
            host.rd(ADDR_COUNTER, d);
            chk_rng(d, 3, 5);
        end
        host.wr(ADDR_CONTROL, 8'h00);
        host.wr(ADDR_CONTROL, 8'h33);
        repeat (256) @(posedge i_core_clk);
        host.rd(ADDR_COUNTER, d);
        chk_rng(d, 3, 5);
        host.wr(ADDR_CONTROL, 8'h00);
        host.wr(ADDR_CONTROL, 8'h20);
        n = 0;
        while (irq !== 1'b1 && n < 600) begin
            step();
            n++;
        end
        chk_rng(16'(n), 511, 515);
        host.wr(ADDR_CONTROL, 8'h00);
        host.rd(ADDR_CONTROL, d);
        chk(d, 8'h80);
        chk(16'(irq), 16'h0001);
        host.clear_flag(ADDR_CONTROL, 8'h00, d);
        host.rd(ADDR_CONTROL, d);
        chk({7'h00, irq, d}, 16'h0000);
        host.rd(ADDR_RESET, d);
        chk(d, 8'h1F);
        overflow(8'h60);
        chk({which, 14'(held)}, {2'b01, 14'(HOLD_T)});
        host.wr(ADDR_RESET, 8'h00);
        host.clear_flag(ADDR_RESET, 8'h00, d);
        chk(d, 8'h9F);
        host.rd(ADDR_RESET, d);
        chk(d, 8'h1F);
        overflow(8'h68);
        chk(16'(which), 16'h0000);
        host.rd(ADDR_CONTROL, d);
        chk(d, 8'h00);
        host.clear_flag(ADDR_RESET, 8'h40, d);
        chk(d, 8'h9F);
        overflow(8'h68);
        chk({which, 14'(held)}, {2'b10, 14'(HOLD_T)});
        host.rd(ADDR_CONTROL, d);
        chk(d, 8'h00);
        host.rd(ADDR_RESET, d);
        chk(d, 8'hDF);
        i_rst_b = 1'b0;
        repeat (3) step();
        i_rst_b = 1'b1;
        host.rd(ADDR_RESET, d);
        chk(d, 8'h1F);
        chk(16'({irq, nmi, crst}), 16'h0000);
        results();
    end
endmodule
